// ==== design/input_sync.sv ====
/*
 * Two-stage synchroniser for the enable and kill pins.
 * Assumes the pins are quasi-static levels; reset value is the undriven
 * (pulled-up, high) level so the output starts disabled.
 */
`timescale 1ns/10ps
`include "psu_ctl_map.svh"

module input_sync
	import psu_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Pin and synchronised level
	input  wire logic pin,
	output logic      level
);

	typedef struct packed
	{
		logic first;
		logic second;
	} sync_t;

	sync_t state;
	sync_t next_state;

	always_comb
	begin
		next_state.first = pin;
		next_state.second = state.first;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state <= '{first: 1'b1, second: 1'b1};
		end
		else
		begin
			state <= next_state;
		end
	end

	assign level = state.second;

endmodule

// ==== design/psu_status_control_signals.sv ====
/*
 * Status and control signal logic of a hot-pluggable power supply module.
 * Drives input-good, output-good and the alert line, gates the main output
 * from the enable and kill pins, and exposes a register view over Avalon-MM.
 * Assumes the analogue front end supplies input-present, output-valid,
 * fault and warning levels, and a digitised address-select level.
 */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`include "psu_ctl_map.svh"

// Notes on behaviour
// - Input-good high while input present and in limits, low on input loss.
// - Input-good falls at least one millisecond before output-good falls; here only with output valid and enabled, else output-good drops at once.
// - Output-good high while main output valid, low when its loss is imminent.
// - Alert driven low on any warning or fault, released high otherwise.
// - Alert releases itself once a warning is gone; a latched fault holds it until the enable pin is cycled.
// - Presence line held to logic ground whenever installed; host reads low.
// - Main output enabled only while the active-low enable pin is low.
// - Enable high or open disables the output; pull-up defaults to off.
// - Cycling the enable pin clears all latched faults.
// - Kill input disables the main output during extraction.
// - Slave addresses come from the address-select analogue level.
// - Clock and data form a PMBus-compatible slave interface; this block has no such pins and only supplies the slave addresses.
module psu_status_control_signals
	import psu_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Host control pins
	input  wire logic        main_output_enable_n,
	input  wire logic        hot_swap_kill,
	// Analogue front end
	input  wire logic        input_present,
	input  wire logic        output_valid,
	input  wire logic [3:0]  fault_event,
	input  wire logic [3:0]  warn_level,
	input  wire logic [7:0]  addr_select_code,
	// Status pins
	output logic             input_good,
	output logic             output_good,
	output logic             output_good_alt,
	output logic             smb_alert_n_out,
	output logic             smb_alert_n_oe,
	output logic             module_presence_n,
	// Power stage and slave addressing
	output logic             main_output_on,
	output logic [6:0]       eeprom_address,
	output logic [6:0]       controller_address,
	// Avalon-MM register port
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);

	typedef struct packed
	{
		pwr_state_t          pwr;
		logic [`WARN_CNT_W-1:0] warn_cnt;
		logic                input_good;
		logic                output_good;
		logic                alert;
		logic [`FAULT_BITS-1:0] faults;
		logic                en_prev;
		logic                force_warn;
		logic [`ADDR_W-1:0]  addr_band;
		logic                bus_done;
		logic [31:0]         rdata;
	} ctl_state_t;

	ctl_state_t state;
	ctl_state_t next_state;

	logic enable_n_sync;
	logic kill_sync;
	logic run_allowed;
	logic any_alert;

	input_sync enable_sync
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin     (main_output_enable_n),
		.level   (enable_n_sync)
	);

	input_sync kill_sync_inst
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin     (hot_swap_kill),
		.level   (kill_sync)
	);

	// Eight equal bands of the 0..3.3 V divider level
	function automatic logic [`ADDR_W-1:0] addr_band_of(input logic [`ADC_W-1:0] code);
		addr_band_of = code[`ADC_W-1 -: `ADDR_W];
	endfunction

	function automatic logic [31:0] status_word(input ctl_state_t s, input logic en_n,
		input logic kill);
		status_word = 32'h0;
		status_word[`ST_INPUT_GOOD] = s.input_good;
		status_word[`ST_OUTPUT_GOOD] = s.output_good;
		status_word[`ST_ALERT] = s.alert;
		status_word[`ST_OUTPUT_ON] = (s.pwr != pwr_off);
		status_word[`ST_ENABLE_REQ] = ~en_n;
		status_word[`ST_KILL] = kill;
	endfunction

	// Output runs only with enable and kill both low and no latched fault
	assign run_allowed = ~enable_n_sync & ~kill_sync & (state.faults == '0);
	assign any_alert = (state.faults != '0) | (warn_level != '0) | state.force_warn;

	always_comb
	begin
		next_state = state;
		next_state.bus_done = 1'b0;
		next_state.en_prev = enable_n_sync;
		next_state.addr_band = addr_band_of(addr_select_code);

		// Faults latch; a new event in the clearing cycle still sets
		if ((state.en_prev == 1'b1) && (enable_n_sync == 1'b0))
		begin
			next_state.faults = fault_event;
		end
		else
		begin
			next_state.faults = state.faults | fault_event;
		end

		next_state.alert = any_alert;

		unique case (state.pwr)
			pwr_off:
			begin
				next_state.input_good = input_present;
				next_state.output_good = 1'b0;
				next_state.warn_cnt = '0;
				if (run_allowed && input_present && output_valid)
				begin
					next_state.pwr = pwr_on;
					next_state.output_good = 1'b1;
				end
			end
			pwr_on:
			begin
				next_state.input_good = 1'b1;
				next_state.output_good = 1'b1;
				if (!run_allowed || !output_valid)
				begin
					// Commanded off or output already collapsing: drop output-good at once, input-good follows input-present
					next_state.pwr = pwr_off;
					next_state.input_good = input_present;
					next_state.output_good = 1'b0;
				end
				else if (!input_present)
				begin
					next_state.pwr = pwr_warning;
					next_state.input_good = 1'b0;
					next_state.warn_cnt = '0;
				end
			end
			pwr_warning:
			begin
				next_state.input_good = 1'b0;
				next_state.warn_cnt = state.warn_cnt + 1'b1;
				// Hold-up energy keeps output-good for the warning interval
				if (!run_allowed || !output_valid)
				begin
					next_state.pwr = pwr_off;
					next_state.output_good = 1'b0;
				end
				else if (32'(state.warn_cnt) >= `WARN_CYCLES - 32'd1)
				begin
					next_state.pwr = pwr_off;
					next_state.output_good = 1'b0;
				end
			end
			default:
			begin
				next_state.pwr = pwr_off;
				next_state.output_good = 1'b0;
			end
		endcase

		// One wait cycle, then answer
		if ((avs_read || avs_write) && !state.bus_done)
		begin
			next_state.bus_done = 1'b1;
			unique case (avs_address)
				`REG_STATUS:
					next_state.rdata = status_word(state, enable_n_sync, kill_sync);
				`REG_CONTROL:
					next_state.rdata = {31'h0, state.force_warn};
				`REG_FAULT:
					next_state.rdata = {24'h0, warn_level, state.faults};
				`REG_ADDRESS:
					next_state.rdata = {29'h0, state.addr_band};
				default:
					next_state.rdata = 32'h0;
			endcase
		end

		// A write lands only in the answer cycle, when waitrequest is low
		if (avs_write && state.bus_done && (avs_address == `REG_CONTROL) && avs_byteenable[0])
		begin
			next_state.force_warn = avs_writedata[`CT_FORCE_WARN];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state <= '{pwr: pwr_off, warn_cnt: '0, input_good: 1'b0,
				output_good: 1'b0, alert: 1'b0, faults: '0, en_prev: 1'b1,
				force_warn: `CT_RESET_VAL, addr_band: '0, bus_done: 1'b0,
				rdata: 32'h0};
		end
		else
		begin
			state <= next_state;
		end
	end

	assign input_good = state.input_good;
	assign output_good = state.output_good;
	assign output_good_alt = state.output_good;
	assign main_output_on = (state.pwr != pwr_off);
	// Open drain: pull low on alert, otherwise released to the pull-up
	assign smb_alert_n_out = 1'b0;
	assign smb_alert_n_oe = state.alert;
	// Tied to logic ground while installed
	assign module_presence_n = 1'b0;
	assign eeprom_address = `EEPROM_BASE | {4'h0, state.addr_band};
	assign controller_address = `CTRL_BASE | {4'h0, state.addr_band};
	assign avs_readdata = state.rdata;
	assign avs_waitrequest = (avs_read || avs_write) && !state.bus_done;

endmodule

// ==== inc/psu_ctl_map.svh ====
/*
 * Constants for the power supply status and control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 40 MHz housekeeping clock and a 32-bit Avalon-MM register port.
 */
`ifndef PSU_CTL_MAP_SVH
`define PSU_CTL_MAP_SVH

// Register byte offsets
`define REG_STATUS      4'h0
`define REG_CONTROL     4'h4
`define REG_FAULT       4'h8
`define REG_ADDRESS     4'hc

// Status register fields
`define ST_INPUT_GOOD   0
`define ST_OUTPUT_GOOD  1
`define ST_ALERT        2
`define ST_OUTPUT_ON    3
`define ST_ENABLE_REQ   4
`define ST_KILL         5

// Control register fields
`define CT_FORCE_WARN   0
`define CT_RESET_VAL    1'b0

// Fault register: latched fault bits, warning bits
`define FAULT_BITS      4
`define WARN_BITS       4

// Early warning between input-good and output-good falling
`define WARN_TIME_US    32'd1000
`define CLK_MHZ         32'd40
`define WARN_CYCLES     (`WARN_TIME_US * `CLK_MHZ)
`define WARN_CNT_W      16

// Address select: converter code width and address band index width
`define ADC_W           8
`define ADDR_W          3
`define EEPROM_BASE     7'h50
`define CTRL_BASE       7'h58

`endif

// ==== inc/psu_ctl_pkg.sv ====
/*
 * Types for the power supply status and control block.
 * Assumes inc/psu_ctl_map.svh is included by the design files.
 */
package psu_ctl_pkg;

	typedef enum logic [1:0]
	{
		pwr_off     = 2'b00,
		pwr_on      = 2'b01,
		pwr_warning = 2'b10
	} pwr_state_t;

endpackage

// ==== tb/host_model.sv ====
/* Host side of the enable and kill pins.
   Assumes the bench sets on_req and kill_req after a clock edge. */
`timescale 1ns/10ps
module host_model
(
	input wire logic sys_clk,
	input wire logic on_req,
	input wire logic kill_req,
	output logic     main_output_enable_n,
	output logic     hot_swap_kill
);
	// Undriven pins sit at the pulled-up, disabled level
	initial
	begin
		main_output_enable_n = 1'b1;
		hot_swap_kill = 1'b1;
	end
	always @(posedge sys_clk)
	begin
		main_output_enable_n <= !on_req;
		hot_swap_kill <= kill_req;
	end
endmodule

// ==== tb/psu_ctl_assertions.sv ====
/* Checker on the status pins, output gating and bus answer.
   Bound to psu_status_control_signals; warning span of 40000 cycles. */
`timescale 1ns/10ps
`include "psu_ctl_map.svh"
module psu_ctl_checker
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       reset,
	// Watched ports
	input wire logic       main_output_enable_n,
	input wire logic       hot_swap_kill,
	input wire logic       input_present,
	input wire logic       output_valid,
	input wire logic [3:0] warn_level,
	input wire logic [7:0] addr_select_code,
	input wire logic       input_good,
	input wire logic       output_good,
	input wire logic       smb_alert_n_out,
	input wire logic       smb_alert_n_oe,
	input wire logic       module_presence_n,
	input wire logic       main_output_on,
	input wire logic [6:0] eeprom_address,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest
);
	localparam int warn_min = 39999;
	logic [15:0] lost;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Cycles since input power went, saturating
	always_ff @(posedge sys_clk)
		lost <= (reset || input_present) ? 16'h0 : lost + {15'h0, lost != 16'hffff};
	a_presence_low: assert property (module_presence_n == 1'b0)
		else $error("presence");
	a_alert_level: assert property (smb_alert_n_out == 1'b0)
		else $error("alert pin");
	a_alert_raise: assert property (|warn_level |-> ##[1:2] smb_alert_n_oe)
		else $error("alert");
	a_enable_off: assert property (main_output_enable_n [*3] |=> !main_output_on)
		else $error("on");
	a_kill_off: assert property (hot_swap_kill [*3] |=> !main_output_on)
		else $error("kill");
	a_input_loss: assert property (!input_present |-> ##[1:2] !input_good)
		else $error("ig");
	a_early_warn: assert property ($fell(output_good) && !input_present && output_valid
		&& !$past(main_output_enable_n || hot_swap_kill, 3) |-> lost >= warn_min)
		else $error("warn");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus");
	a_slave_addr: assert property ($stable(addr_select_code) [*3]
		|-> eeprom_address == (`EEPROM_BASE | {4'h0, addr_select_code[7:5]}))
		else $error("addr");
	cover property ($fell(input_good));
	cover property ($rose(main_output_on));
	cover property ($rose(smb_alert_n_oe));
endmodule
bind psu_status_control_signals psu_ctl_checker u_chk (.*);

// ==== tb/tb_top.sv ====
/* Bench: host pins via host_model, front end and bus driven here,
   outputs compared with a model. Assumes the 40000-cycle warning span. */
`timescale 1ns/10ps
module tb_top;
	logic        sys_clk, reset, on_req, kill_req, input_present, output_valid, flt;
	logic        main_output_enable_n, hot_swap_kill, input_good, output_good;
	logic        output_good_alt, smb_alert_n_out, smb_alert_n_oe, module_presence_n;
	logic        main_output_on, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  fault_event, warn_level, avs_address, avs_byteenable, f;
	logic [7:0]  addr_select_code;
	logic [6:0]  eeprom_address, controller_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	int          err_count, checked;
	host_model u_host (.*);
	psu_status_control_signals u_dut (.*);
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest && ++n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk(32'(n < 50), 32'h1);
	endtask
	// Waits out the two-flop synchroniser and host pin delay
	task automatic look();
		logic o;
		repeat (5) @(posedge sys_clk);
		o = on_req && !kill_req && !flt && input_present && output_valid;
		chk({input_good, output_good, output_good_alt, main_output_on, module_presence_n},
			{input_present, o, o, o, 1'b0});
	endtask
	task automatic end_of_test();
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#(60000 * 25);
		err_count++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(32'h28d4));
		{reset, input_present, output_valid, avs_byteenable} = {3'b111, 4'hf};
		{on_req, kill_req, flt, avs_read, avs_write} = 5'h0;
		{fault_event, warn_level, avs_address, avs_writedata} = '0;
		addr_select_code = 8'($urandom);
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		look();
		on_req <= 1'b1;
		look();
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h1b);
		bus(1'b0, 4'hc, 32'h0);
		chk(rd, {29'h0, addr_select_code[7:5]});
		chk({eeprom_address, controller_address}, {4'ha, addr_select_code[7:5], 4'hb,
			addr_select_code[7:5]});
		bus(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 4'h4, 32'h1);
		bus(1'b0, 4'h4, 32'h0);
		chk(rd, 32'h1);
		chk(32'(smb_alert_n_oe), 32'h1);
		bus(1'b1, 4'h4, 32'h0);
		kill_req <= 1'b1;
		look();
		kill_req <= 1'b0;
		look();
		for (int i = 0; i < 4; i++)
		begin
			warn_level <= 4'(1 << i);
			repeat (3) @(posedge sys_clk);
			chk(smb_alert_n_oe, 1'b1);
			warn_level <= 4'h0;
			repeat (3) @(posedge sys_clk);
			chk(smb_alert_n_oe, 1'b0);
		end
		f = 4'(1 << ($urandom % 4));
		fault_event <= f;
		flt = 1'b1;
		@(posedge sys_clk);
		fault_event <= 4'h0;
		look();
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, {28'h0, f});
		chk(32'(smb_alert_n_oe), 32'h1);
		on_req <= 1'b0;
		look();
		on_req <= 1'b1;
		flt = 1'b0;
		// The output may only come on one edge after the fault clear itself
		@(posedge sys_clk);
		look();
		chk(32'(smb_alert_n_oe), 32'h0);
		output_valid <= 1'b0;
		look();
		output_valid <= 1'b1;
		look();
		input_present <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({input_good, output_good}, 2'b01);
		// Input-good fell 40000 edges ago: output-good must still stand here
		repeat (39998) @(posedge sys_clk);
		chk(output_good, 1'b1);
		repeat (2) @(posedge sys_clk);
		chk(output_good, 1'b0);
		input_present <= 1'b1;
		look();
		end_of_test();
	end
endmodule
